// >>> rtl/gqw_map.vh
// constants for the gpio input qualifier and idle wake block
// assumes a single 125 MHz system clock and no software bus
`ifndef GQW_MAP_VH
`define GQW_MAP_VH

`define GQW_PRD_W        8
`define GQW_SEL_SYNC     2'b00
`define GQW_SEL_Q3       2'b01
`define GQW_SEL_Q6       2'b10
`define GQW_SEL_ASYNC    2'b11
`define GQW_SEL_RST      2'b00
`define GQW_GROUP_PINS   8
`define GQW_SAMP_3       3
`define GQW_SAMP_6       6
`define GQW_CFG_DLY      2
`define GQW_RESUME_FAST  12'h014
`define GQW_RESUME_SLEEP 12'h41a
`define GQW_OSC_WAIT     5

`endif

// >>> rtl/gqw_top.v
// gpio input qualifier with per-group sampling and idle wake sequencing
// assumes pins synchronous-ish inputs, config from core logic, one clock
`timescale 1ns/1ps
`default_nettype none
`include "gqw_map.vh"

module gqw_top #(
    parameter NGRP       = 2,
    parameter RESUME_SLP = `GQW_RESUME_SLEEP
) (
    input  wire                       clk,
    input  wire                       rst_n,
    input  wire [NGRP*8-1:0]          pin_in,
    input  wire [NGRP*8-1:0]          pin_mux_reg,
    input  wire                       cfg_we,
    input  wire [NGRP*16-1:0]         qual_select_reg,
    input  wire [NGRP*8-1:0]          port_ctrl_reg,
    input  wire                       idle_req,
    input  wire                       flash_sleep,
    input  wire                       qual_used,
    input  wire [7:0]                 qual_window,
    input  wire                       irq_enabled,
    input  wire                       watchdog_interrupt,
    input  wire                       external_reset_pin,
    output wire [NGRP*8-1:0]          pin_qual_ff,
    output wire [NGRP*8-1:0]          pin_mux_act,
    output reg                        idle_ff,
    output reg                        resume_ff
);

    localparam ST_RUN  = 2'd0;
    localparam ST_IDLE = 2'd1;
    localparam ST_WAKE = 2'd2;

    // config shadow: writes reach the qualifiers two clocks later
    reg  [NGRP*16-1:0] sel_wr_ff;
    reg  [NGRP*8-1:0]  mux_wr_ff;
    reg  [NGRP*16-1:0] sel_ff;
    reg  [NGRP*8-1:0]  mux_ff;
    reg                cfg_pend_ff;
    reg  [NGRP*16-1:0] nxt_sel_wr;
    reg  [NGRP*8-1:0]  nxt_mux_wr;
    reg  [NGRP*16-1:0] nxt_sel;
    reg  [NGRP*8-1:0]  nxt_mux;
    reg                nxt_cfg_pend;

    always @* begin
        nxt_sel_wr   = sel_wr_ff;
        nxt_mux_wr   = mux_wr_ff;
        nxt_sel      = sel_ff;
        nxt_mux      = mux_ff;
        nxt_cfg_pend = cfg_we;
        if (cfg_we) begin
            nxt_sel_wr = qual_select_reg;
            nxt_mux_wr = pin_mux_reg;
        end
        // staged copy lands one clock after capture
        if (cfg_pend_ff) begin
            nxt_sel = sel_wr_ff;
            nxt_mux = mux_wr_ff;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_wr_ff   <= {NGRP*8{`GQW_SEL_RST}};
            mux_wr_ff   <= {NGRP*8{1'b0}};
            sel_ff      <= {NGRP*8{`GQW_SEL_RST}};
            mux_ff      <= {NGRP*8{1'b0}};
            cfg_pend_ff <= 1'b0;
        end else begin
            sel_wr_ff   <= nxt_sel_wr;
            mux_wr_ff   <= nxt_mux_wr;
            sel_ff      <= nxt_sel;
            mux_ff      <= nxt_mux;
            cfg_pend_ff <= nxt_cfg_pend;
        end
    end

    assign pin_mux_act = mux_ff;

    // two-flop synchroniser for every pin
    reg [NGRP*8-1:0] sync1_ff;
    reg [NGRP*8-1:0] sync2_ff;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= {NGRP*8{1'b0}};
            sync2_ff <= {NGRP*8{1'b0}};
        end else begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
        end
    end

    genvar g;
    genvar b;
    generate
        for (g = 0; g < NGRP; g = g + 1) begin : grp
            // per-group sample strobe; period 0 gives every clock
            reg  [8:0] cnt_ff;
            reg  [8:0] nxt_cnt;
            wire [7:0] prd = port_ctrl_reg[g*8 +: 8];
            wire [8:0] prd2 = {prd, 1'b0};
            wire       stb = (prd == 8'h00) || (cnt_ff == 9'h000);
            // counter parks at zero in period 0 and is clamped when the period shrinks
            always @* begin
                nxt_cnt = cnt_ff - 9'h001;
                if (prd == 8'h00)
                    nxt_cnt = 9'h000;
                else if (stb || (cnt_ff >= prd2))
                    nxt_cnt = prd2 - 9'h001;
            end
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n)
                    cnt_ff <= 9'h000;
                else
                    cnt_ff <= nxt_cnt;
            end
            for (b = 0; b < 8; b = b + 1) begin : pin
                localparam P = g*8 + b;
                reg  [5:0] hist_ff;
                wire [1:0] sel = sel_ff[2*P +: 2];
                wire [5:0] nxt_hist = {hist_ff[4:0], sync2_ff[P]};
                wire       all1_3 = &nxt_hist[2:0];
                wire       all0_3 = ~|nxt_hist[2:0];
                wire       all1_6 = &nxt_hist;
                wire       all0_6 = ~|nxt_hist;
                reg        q_ff;
                reg        nxt_q;
                assign pin_qual_ff[P] = q_ff;
                always @* begin
                    nxt_q = q_ff;
                    case (sel)
                        `GQW_SEL_SYNC:  nxt_q = sync2_ff[P];
                        `GQW_SEL_Q3: begin
                            if (stb && (all1_3 || all0_3))
                                nxt_q = nxt_hist[0];
                        end
                        `GQW_SEL_Q6: begin
                            if (stb && (all1_6 || all0_6))
                                nxt_q = nxt_hist[0];
                        end
                        `GQW_SEL_ASYNC: nxt_q = pin_in[P];
                        default:        nxt_q = sync2_ff[P];
                    endcase
                end
                always @(posedge clk or negedge rst_n) begin
                    if (!rst_n) begin
                        hist_ff <= 6'h00;
                        q_ff    <= 1'b0;
                    end else begin
                        if (stb)
                            hist_ff <= nxt_hist;
                        q_ff <= nxt_q;
                    end
                end
            end
        end
    endgenerate

    // idle entry, wake on interrupt/watchdog/reset, bounded resume
    reg  [1:0]  st_ff;
    reg  [11:0] rcnt_ff;
    reg  [1:0]  nxt_st;
    reg  [11:0] nxt_rcnt;
    reg         nxt_idle;
    reg         nxt_resume;
    wire        wake = irq_enabled | watchdog_interrupt | external_reset_pin;
    wire [11:0] fast_lim = `GQW_RESUME_FAST;
    wire [11:0] slow_lim = RESUME_SLP[11:0];
    wire [11:0] base_lim = flash_sleep ? slow_lim : fast_lim;
    wire [11:0] lim = qual_used ? base_lim + {4'h0, qual_window} : base_lim;
    wire        lim_hit = (rcnt_ff >= lim - 12'h001);

    always @* begin
        nxt_st     = st_ff;
        nxt_rcnt   = rcnt_ff;
        nxt_idle   = idle_ff;
        nxt_resume = 1'b0;
        case (st_ff)
            ST_RUN: begin
                if (idle_req) begin
                    nxt_st   = ST_IDLE;
                    nxt_idle = 1'b1;
                end
            end
            ST_IDLE: begin
                if (wake) begin
                    nxt_st   = ST_WAKE;
                    nxt_rcnt = 12'h001;
                end
            end
            ST_WAKE: begin
                // resume once the count reaches lim - 1, lim set by flash_sleep, qual_used and qual_window, never beyond the limit
                if (lim_hit) begin
                    nxt_st     = ST_RUN;
                    nxt_idle   = 1'b0;
                    nxt_resume = 1'b1;
                end else begin
                    nxt_rcnt = rcnt_ff + 12'h001;
                end
            end
            default: begin
                nxt_st   = ST_RUN;
                nxt_idle = 1'b0;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff     <= ST_RUN;
            rcnt_ff   <= 12'h000;
            idle_ff   <= 1'b0;
            resume_ff <= 1'b0;
        end else begin
            st_ff     <= nxt_st;
            rcnt_ff   <= nxt_rcnt;
            idle_ff   <= nxt_idle;
            resume_ff <= nxt_resume;
        end
    end

endmodule
`default_nettype wire

// >>> sim/gqw_chk.sv
// checker on the config and idle wake ports
// bound from the bench to gqw_top
`timescale 1ns/1ps
`default_nettype none
module gqw_chk #(parameter NGRP = 2, parameter RESUME_SLP = 1050) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [NGRP*8-1:0] pin_mux_reg,
    input wire logic              cfg_we,
    input wire logic              idle_req,
    input wire logic              flash_sleep,
    input wire logic              qual_used,
    input wire logic [7:0]        qual_window,
    input wire logic              irq_enabled,
    input wire logic              watchdog_interrupt,
    input wire logic              external_reset_pin,
    input wire logic [NGRP*8-1:0] pin_mux_act,
    input wire logic              idle_ff,
    input wire logic              resume_ff
);
    logic        wk_ff;
    logic [11:0] cnt_ff;
    wire  [11:0] lim = 12'((flash_sleep ? RESUME_SLP : 20) + (qual_used ? qual_window : 8'h00));
    wire         wake = irq_enabled | watchdog_interrupt | external_reset_pin;
    // cycles since first wake seen in idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wk_ff  <= 1'b0;
            cnt_ff <= 12'h0;
        end else if (resume_ff) begin
            wk_ff <= 1'b0;
        end else if (!wk_ff && idle_ff && wake) begin
            wk_ff  <= 1'b1;
            cnt_ff <= 12'h1;
        end else if (wk_ff) begin
            cnt_ff <= cnt_ff + 12'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_mux_late: assert property ($past(cfg_we, 2) |-> pin_mux_act == $past(pin_mux_reg, 2))
        else $error("mux config late");
    chk_mux_early: assert property (!$past(cfg_we, 2) |-> $stable(pin_mux_act))
        else $error("mux config moved");
    chk_resume_time: assert property (resume_ff |-> wk_ff && cnt_ff == lim)
        else $error("resume latency wrong");
    chk_resume_pulse: assert property (resume_ff |=> !resume_ff)
        else $error("resume too long");
    chk_idle_exit: assert property (resume_ff |-> !idle_ff && $past(idle_ff))
        else $error("resume outside idle");
    chk_idle_fall: assert property ($fell(idle_ff) |-> resume_ff)
        else $error("idle left silently");
    chk_idle_entry: assert property ($rose(idle_ff) |-> $past(idle_req))
        else $error("idle without request");
    chk_run_quiet: assert property (!idle_ff && !$past(idle_ff) |-> !resume_ff)
        else $error("resume in run");
endmodule
`default_nettype wire

// >>> sim/gqw_pins.sv
// far-side driver of the sixteen input pins
// holds each level for hold cycles, optional one-cycle glitch first
`timescale 1ns/1ps
`default_nettype none
module gqw_pins (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [15:0] val,
    input  wire logic [15:0] glt,
    input  wire logic [7:0]  hold,
    output var  logic [15:0] pin_in,
    output wire logic        busy
);
    logic [15:0] lvl_ff = 16'h0;
    logic [7:0]  cnt_ff = 8'h0;
    initial pin_in = 16'h0;
    assign busy = cnt_ff != 8'h0;
    always @(posedge clk) begin
        if (go) begin
            pin_in <= val ^ glt;
            lvl_ff <= val;
            cnt_ff <= hold;
        end else begin
            pin_in <= lvl_ff;
            if (busy) cnt_ff <= cnt_ff - 8'h1;
        end
    end
endmodule
`default_nettype wire

// >>> sim/tb_gqw_top.sv
// bench for the gpio qualifier and idle wake block
// gqw_pins drives the pins, gqw_chk is bound below
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("Error %s exp %0h got %0h", n, e, g); end end
module tb_gqw_top;
    localparam RSLP = 30;
    logic        clk = 0, rst_n = 0, cfg_we = 0, idle_req = 0, fs = 0, qu = 0, go = 0, armed = 0;
    logic        idle, res, busy;
    logic [2:0]  wk = 0;
    logic [7:0]  win = 0, hold = 0;
    logic [15:0] mux = 0, prd = 0, val = 0, glt = 0, pin, q, mact, prev = 0, v = 0, e16;
    logic [31:0] sel = 0;
    logic [11:0] e12;
    logic [15:0] pq[$];
    logic [11:0] rq[$];
    int          mismatches = 0, cmp_count = 0, cyc = 0, t0 = 0, p = 0;
    always #4 clk = ~clk;
    gqw_top #(.NGRP(2), .RESUME_SLP(RSLP)) u_dut (.clk(clk), .rst_n(rst_n), .pin_in(pin), .pin_mux_reg(mux),
        .cfg_we(cfg_we), .qual_select_reg(sel), .port_ctrl_reg(prd), .idle_req(idle_req), .flash_sleep(fs),
        .qual_used(qu), .qual_window(win), .irq_enabled(wk[0]), .watchdog_interrupt(wk[1]),
        .external_reset_pin(wk[2]), .pin_qual_ff(q), .pin_mux_act(mact), .idle_ff(idle), .resume_ff(res));
    gqw_pins u_pins (.clk(clk), .go(go), .val(val), .glt(glt), .hold(hold), .pin_in(pin), .busy(busy));
    always @(posedge clk) begin
        cyc++;
        if (idle && |wk && !armed) begin
            armed = 1;
            t0 = cyc;
        end
        if (res) begin
            armed = 0;
            e12 = rq.pop_front();
            `CHK("resume", e12, 12'(cyc - t0))
        end
        if (rst_n && q !== prev) begin
            prev = q;
            e16 = pq.pop_front();
            `CHK("pins", e16, q)
        end
    end
    task automatic drive(input logic [15:0] nv, input logic [15:0] gm);
        @(posedge clk);
        go <= 1;
        val <= nv;
        glt <= gm;
        hold <= 8'(16 * p + 8);
        if (nv !== v) pq.push_back(nv);
        v = nv;
        @(posedge clk);
        go <= 0;
        do @(negedge clk); while (busy);
    endtask
    task automatic close_out;
        if (mismatches == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        void'($urandom(68));
        repeat (10) @(posedge clk);
        rst_n <= 1;
        `CHK("reset", 34'h0, {q, mact, idle, res})
        for (int m = 0; m < 4; m++) begin
            p = 1 + $urandom % 3;
            @(posedge clk);
            cfg_we <= 1;
            sel <= {16{m[1:0]}};
            mux <= 16'($urandom);
            prd <= {p[7:0], 8'h00};
            @(posedge clk);
            cfg_we <= 0;
            repeat (4) @(posedge clk);
            for (int g = 0; g < 2; g++) drive(v ^ (16'(8'($urandom) | 8'h01) << (8 * g)), 16'h0);
            if (m == 1 || m == 2) drive(v, 16'h0101);
        end
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            wk <= 3'(1 << (i % 3));
            repeat (2) @(posedge clk);
            wk <= 3'h0;
            fs <= i % 6 >= 3;
            qu <= i >= 6;
            win <= 8'($urandom % 8);
            idle_req <= 1;
            @(posedge clk);
            idle_req <= 0;
            repeat (6) @(posedge clk);
            rq.push_back(12'((i % 6 >= 3 ? RSLP : 20) + (i >= 6 ? win : 8'h00)));
            wk <= 3'(1 << (i % 3));
            repeat (qu ? 5 + win : 2) @(posedge clk);
            wk <= 3'h0;
            for (int k = 0; k < 1200 && res !== 1'b1; k++) @(negedge clk);
        end
        repeat (5) @(posedge clk);
        `CHK("queues", 0, pq.size() + rq.size())
        close_out;
    end
    initial begin
        #100000;
        mismatches++;
        close_out;
    end
endmodule
bind gqw_top gqw_chk #(.NGRP(NGRP), .RESUME_SLP(RESUME_SLP)) u_chk (.clk(clk), .rst_n(rst_n),
    .pin_mux_reg(pin_mux_reg), .cfg_we(cfg_we), .idle_req(idle_req), .flash_sleep(flash_sleep),
    .qual_used(qual_used), .qual_window(qual_window), .irq_enabled(irq_enabled),
    .watchdog_interrupt(watchdog_interrupt), .external_reset_pin(external_reset_pin),
    .pin_mux_act(pin_mux_act), .idle_ff(idle_ff), .resume_ff(resume_ff));
`default_nettype wire
